// [hw/mrr_exec.sv]
// Execution of the move, rotate and return instruction group of the core.
// Assumes one instruction clock, a synchronous active-high reset, and that
// the decoder outside presents already classified instructions.
`timescale 1ns/1ps
`include "mrr_consts.svh"

// What this block does
// (RULE_01) load_literal_op puts its 8-bit literal in work_reg in one cycle.
// (RULE_02) No-operation only advances the program counter, in one cycle.
// (RULE_03) copy_register_op moves file register 0..63 to work_reg or itself.
// (RULE_04) copy_register_op sets the zero flag from the moved value.
// (RULE_05) interrupt_exit_op pops stack to PC, sets irq enable, two cycles.
// (RULE_06) exit_with_literal_op loads literal, pops, enables irqs, 2 cycles.
// (RULE_07) subroutine_exit_op pops stack into PC, no flags, two cycles.
// (RULE_08) rotate_left_carry_op: carry into bit 0, bit 7 out to carry.
// (RULE_09) rotate_right_carry_op: carry into bit 7, bit 0 out to carry.
// (RULE_10) Unnamed flags hold; PC advances by one after non-return ops.
module mrr_exec #(
  parameter int STACK_DEPTH = `MRR_STACK_DEPTH,
  parameter int FILE_DEPTH = `MRR_FILE_DEPTH
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic INSTR_VALID,
  input wire mrr_pkg::mrr_instr_t INSTR,
  output logic INSTR_READY,
  input wire logic STACK_PUSH,
  input wire logic [`MRR_PC_W-1:0] STACK_PUSH_PC,
  input wire logic IRQ_ENABLE_CLEAR,
  input wire logic FILE_LOAD,
  input wire logic [`MRR_ADDR_W-1:0] FILE_LOAD_ADDR,
  input wire logic [`MRR_DATA_W-1:0] FILE_LOAD_DATA,
  output logic [`MRR_DATA_W-1:0] WORK_REG,
  output logic [`MRR_PC_W-1:0] PC,
  output mrr_pkg::mrr_flags_t FLAGS,
  output logic GLOBAL_IRQ_ENABLE,
  output logic [$clog2(STACK_DEPTH+1)-1:0] STACK_LEVEL,
  output mrr_pkg::mrr_wr_t FILE_WRITE
);

  localparam int LW = $clog2(STACK_DEPTH+1);
  localparam int SW = $clog2(STACK_DEPTH);
  localparam logic [LW-1:0] LEVEL_ONE = LW'(1);
  localparam logic [LW-1:0] LEVEL_FULL = LW'(STACK_DEPTH);
  localparam logic [`MRR_PC_W-1:0] PC_STEP = `MRR_PC_W'(`MRR_ONE_CYCLE);

  // Carry enters the low end; the old top bit becomes the new carry.
  function automatic logic [`MRR_DATA_W:0] rot_left(
    input logic [`MRR_DATA_W-1:0] value,
    input logic carry_in
  );
    rot_left = {value, carry_in};
  endfunction

  // Carry enters the top end; the old low bit becomes the new carry.
  function automatic logic [`MRR_DATA_W:0] rot_right(
    input logic [`MRR_DATA_W-1:0] value,
    input logic carry_in
  );
    rot_right = {value[`MRR_LSB], carry_in, value[`MRR_MSB:1]};
  endfunction

  mrr_pkg::mrr_state_t state_reg;
  mrr_pkg::mrr_state_t state_next;
  mrr_pkg::mrr_op_t pop_op_reg;
  mrr_pkg::mrr_op_t pop_op_next;
  logic [`MRR_DATA_W-1:0] pop_lit_reg;
  logic [`MRR_DATA_W-1:0] pop_lit_next;
  logic ready_reg;
  logic ready_next;
  logic [`MRR_DATA_W-1:0] work_reg;
  logic [`MRR_DATA_W-1:0] work_next;
  logic [`MRR_PC_W-1:0] pc_reg;
  logic [`MRR_PC_W-1:0] pc_next;
  mrr_pkg::mrr_flags_t flags_reg;
  mrr_pkg::mrr_flags_t flags_next;
  logic irq_en_reg;
  logic irq_en_next;
  logic [LW-1:0] level_reg;
  logic [LW-1:0] level_next;
  mrr_pkg::mrr_wr_t wr_reg;
  mrr_pkg::mrr_wr_t wr_next;
  logic [`MRR_PC_W-1:0] stack_reg [0:STACK_DEPTH-1];
  logic [`MRR_PC_W-1:0] stack_next [0:STACK_DEPTH-1];
  logic [`MRR_DATA_W-1:0] file_reg [0:FILE_DEPTH-1];
  logic [`MRR_DATA_W-1:0] file_next [0:FILE_DEPTH-1];

  always_comb begin
    logic [`MRR_DATA_W-1:0] operand;
    logic [`MRR_DATA_W:0] rot;
    logic [`MRR_DATA_W-1:0] result;
    logic result_valid;
    logic [SW-1:0] top;
    operand = file_reg[INSTR.addr];
    rot = '0;
    result = operand;
    result_valid = 1'b0;
    top = '0;
    state_next = state_reg;
    pop_op_next = pop_op_reg;
    pop_lit_next = pop_lit_reg;
    ready_next = ready_reg;
    work_next = work_reg;
    pc_next = pc_reg;
    flags_next = flags_reg;
    irq_en_next = irq_en_reg;
    level_next = level_reg;
    wr_next = '0;
    stack_next = stack_reg;
    file_next = file_reg;
    if (IRQ_ENABLE_CLEAR) begin
      irq_en_next = 1'b0;
    end
    if (FILE_LOAD) begin
      file_next[FILE_LOAD_ADDR] = FILE_LOAD_DATA;
    end
    case (state_reg)
      mrr_pkg::ST_FETCH: begin
        if (INSTR_VALID && ready_reg) begin
          // Non-return ops step the PC; flags not listed are left alone.
          pc_next = pc_reg + PC_STEP; // [RULE_10]
          case (INSTR.op)
            mrr_pkg::OP_NOP: begin
              // Only the PC step above takes place. [RULE_02]
            end
            mrr_pkg::OP_LOAD_LITERAL: begin
              work_next = INSTR.literal; // [RULE_01]
            end
            mrr_pkg::OP_COPY_REGISTER: begin
              result = operand; // [RULE_03]
              result_valid = 1'b1;
              flags_next.zero = (operand == `MRR_DATA_RESET); // [RULE_04]
            end
            mrr_pkg::OP_ROTATE_LEFT_CARRY: begin
              rot = rot_left(operand, flags_reg.carry); // [RULE_08]
              result = rot[`MRR_DATA_W-1:0];
              flags_next.carry = rot[`MRR_DATA_W];
              result_valid = 1'b1;
            end
            mrr_pkg::OP_ROTATE_RIGHT_CARRY: begin
              rot = rot_right(operand, flags_reg.carry); // [RULE_09]
              result = rot[`MRR_DATA_W-1:0];
              flags_next.carry = rot[`MRR_DATA_W];
              result_valid = 1'b1;
            end
            mrr_pkg::OP_INTERRUPT_EXIT,
            mrr_pkg::OP_EXIT_WITH_LITERAL,
            mrr_pkg::OP_SUBROUTINE_EXIT: begin
              // The second cycle does the pop, so the PC is held here.
              pc_next = pc_reg; // [RULE_05] [RULE_06] [RULE_07]
              pop_op_next = INSTR.op;
              pop_lit_next = INSTR.literal;
              ready_next = 1'b0;
              state_next = mrr_pkg::ST_RETURN;
            end
            default: begin
              pc_next = pc_reg;
            end
          endcase
          if (result_valid) begin
            if (INSTR.dest == `MRR_DEST_FILE) begin
              file_next[INSTR.addr] = result; // [RULE_03]
              wr_next.strobe = 1'b1;
              wr_next.addr = INSTR.addr;
              wr_next.data = result;
            end else begin
              work_next = result; // [RULE_03]
            end
          end
        end else if (STACK_PUSH && level_reg != LEVEL_FULL) begin
          // Pushes are taken only while no instruction is being taken.
          stack_next[SW'(level_reg)] = STACK_PUSH_PC;
          level_next = level_reg + LEVEL_ONE;
        end
      end
      mrr_pkg::ST_RETURN: begin
        // An empty stack is not popped further; entry 0 is reloaded.
        if (level_reg != '0) begin
          top = SW'(level_reg - LEVEL_ONE);
          level_next = level_reg - LEVEL_ONE; // [RULE_05] [RULE_07]
        end
        pc_next = stack_reg[top]; // [RULE_05] [RULE_06] [RULE_07]
        case (pop_op_reg)
          mrr_pkg::OP_INTERRUPT_EXIT: begin
            irq_en_next = 1'b1; // [RULE_05]
          end
          mrr_pkg::OP_EXIT_WITH_LITERAL: begin
            irq_en_next = 1'b1; // [RULE_06]
            work_next = pop_lit_reg; // [RULE_06]
          end
          default: begin
            // A plain subroutine exit touches no flag. [RULE_07]
          end
        endcase
        ready_next = 1'b1;
        state_next = mrr_pkg::ST_FETCH;
      end
      default: begin
        ready_next = 1'b1;
        state_next = mrr_pkg::ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg <= mrr_pkg::ST_FETCH;
      pop_op_reg <= mrr_pkg::OP_NOP;
      pop_lit_reg <= `MRR_DATA_RESET;
      ready_reg <= 1'b1;
      work_reg <= `MRR_DATA_RESET;
      pc_reg <= `MRR_PC_RESET;
      flags_reg <= '{carry: `MRR_FLAG_RESET, zero: `MRR_FLAG_RESET};
      irq_en_reg <= `MRR_IRQ_EN_RESET;
      level_reg <= '0;
      wr_reg <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_reg[i] <= `MRR_PC_RESET;
      end
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_reg[i] <= `MRR_DATA_RESET;
      end
    end else begin
      state_reg <= state_next;
      pop_op_reg <= pop_op_next;
      pop_lit_reg <= pop_lit_next;
      ready_reg <= ready_next;
      work_reg <= work_next;
      pc_reg <= pc_next;
      flags_reg <= flags_next;
      irq_en_reg <= irq_en_next;
      level_reg <= level_next;
      wr_reg <= wr_next;
      stack_reg <= stack_next;
      file_reg <= file_next;
    end
  end

  assign INSTR_READY = ready_reg;
  assign WORK_REG = work_reg;
  assign PC = pc_reg;
  assign FLAGS = flags_reg;
  assign GLOBAL_IRQ_ENABLE = irq_en_reg;
  assign STACK_LEVEL = level_reg;
  assign FILE_WRITE = wr_reg;

endmodule

// [hw/mrr_consts.svh]
// Constants for the move, rotate and return execution block.
// Assumes inclusion by bare name from the package and the block.
`ifndef MRR_CONSTS_SVH
`define MRR_CONSTS_SVH

`define MRR_DATA_W 8
`define MRR_ADDR_W 6
`define MRR_PC_W 10
`define MRR_FILE_DEPTH 64
`define MRR_STACK_DEPTH 8
`define MRR_ONE_CYCLE 1
`define MRR_RETURN_CYCLES 2
`define MRR_PC_RESET 10'h000
`define MRR_DATA_RESET 8'h00
`define MRR_FLAG_RESET 1'b0
`define MRR_IRQ_EN_RESET 1'b0
`define MRR_DEST_WORK 1'b0
`define MRR_DEST_FILE 1'b1
`define MRR_MSB 7
`define MRR_LSB 0

`endif

// [hw/mrr_pkg.sv]
// Types shared by the execution block and its surroundings.
// Assumes mrr_consts.svh is on the include path.
`include "mrr_consts.svh"

package mrr_pkg;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_LOAD_LITERAL,
    OP_COPY_REGISTER,
    OP_INTERRUPT_EXIT,
    OP_EXIT_WITH_LITERAL,
    OP_SUBROUTINE_EXIT,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY
  } mrr_op_t;

  typedef struct packed {
    mrr_op_t op;
    logic [`MRR_DATA_W-1:0] literal;
    logic [`MRR_ADDR_W-1:0] addr;
    logic dest;
  } mrr_instr_t;

  typedef struct packed {
    logic carry;
    logic zero;
  } mrr_flags_t;

  typedef struct packed {
    logic strobe;
    logic [`MRR_ADDR_W-1:0] addr;
    logic [`MRR_DATA_W-1:0] data;
  } mrr_wr_t;

  typedef enum logic {
    ST_FETCH,
    ST_RETURN
  } mrr_state_t;

endpackage

// [verification/mrr_exec_assertions.sv]
// Checker for the move, rotate and return execution block.
// Assumes it is bound to mrr_exec and sees only that module's ports.
`timescale 1ns/1ps
`include "mrr_consts.svh"
module mrr_checker #(
  parameter int STACK_DEPTH = `MRR_STACK_DEPTH
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic INSTR_VALID,
  input wire mrr_pkg::mrr_instr_t INSTR,
  input wire logic INSTR_READY,
  input wire logic [`MRR_DATA_W-1:0] WORK_REG,
  input wire logic [`MRR_PC_W-1:0] PC,
  input wire mrr_pkg::mrr_flags_t FLAGS,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic [$clog2(STACK_DEPTH+1)-1:0] STACK_LEVEL,
  input wire mrr_pkg::mrr_wr_t FILE_WRITE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  logic tk;
  logic rt;
  assign tk = INSTR_VALID && INSTR_READY;
  assign rt = INSTR.op inside {mrr_pkg::OP_INTERRUPT_EXIT,
    mrr_pkg::OP_EXIT_WITH_LITERAL, mrr_pkg::OP_SUBROUTINE_EXIT};
  // An empty stack is excluded because the level then stays at zero.
  sequence s_pop_take;
    tk && rt && STACK_LEVEL != 0;
  endsequence
  sequence s_pop_done;
    !INSTR_READY ##1 INSTR_READY;
  endsequence
  property p_lit;
    tk && INSTR.op == mrr_pkg::OP_LOAD_LITERAL |=>
      WORK_REG == $past(INSTR.literal) && FLAGS == $past(FLAGS);
  endproperty
  a_lit: assert property (p_lit)
    else $error("literal load wrong");
  property p_nop;
    tk && INSTR.op == mrr_pkg::OP_NOP |=> !FILE_WRITE.strobe &&
      WORK_REG == $past(WORK_REG) && FLAGS == $past(FLAGS);
  endproperty
  a_nop: assert property (p_nop)
    else $error("no-operation changed state");
  property p_step;
    tk && !rt |=> PC == $past(PC) + 10'h001;
  endproperty
  a_step: assert property (p_step)
    else $error("program counter did not step");
  property p_cpw;
    tk && INSTR.op == mrr_pkg::OP_COPY_REGISTER && !INSTR.dest |=>
      !FILE_WRITE.strobe && FLAGS.zero == (WORK_REG == 8'h00);
  endproperty
  a_cpw: assert property (p_cpw)
    else $error("copy to work register wrong");
  property p_cpf;
    tk && INSTR.op == mrr_pkg::OP_COPY_REGISTER && INSTR.dest |=>
      FILE_WRITE.strobe && FILE_WRITE.addr == $past(INSTR.addr) &&
      FLAGS.zero == (FILE_WRITE.data == 8'h00);
  endproperty
  a_cpf: assert property (p_cpf)
    else $error("copy write-back wrong");
  property p_rol;
    tk && INSTR.op == mrr_pkg::OP_ROTATE_LEFT_CARRY && INSTR.dest |=>
      FILE_WRITE.strobe && FILE_WRITE.data[0] == $past(FLAGS.carry);
  endproperty
  a_rol: assert property (p_rol)
    else $error("left rotate carry-in wrong");
  property p_ror;
    tk && INSTR.op == mrr_pkg::OP_ROTATE_RIGHT_CARRY && INSTR.dest |=>
      FILE_WRITE.strobe && FILE_WRITE.data[7] == $past(FLAGS.carry);
  endproperty
  a_ror: assert property (p_ror)
    else $error("right rotate carry-in wrong");
  property p_pop;
    s_pop_take |=> s_pop_done ##0
      (STACK_LEVEL == $past(STACK_LEVEL, 2) - 1 && FLAGS == $past(FLAGS, 2));
  endproperty
  a_pop: assert property (p_pop)
    else $error("return pop wrong");
  property p_irq_en;
    tk && INSTR.op inside {mrr_pkg::OP_INTERRUPT_EXIT,
      mrr_pkg::OP_EXIT_WITH_LITERAL} |=> ##1 GLOBAL_IRQ_ENABLE;
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("interrupt enable not set");
  property p_rlit;
    tk && INSTR.op == mrr_pkg::OP_EXIT_WITH_LITERAL |=>
      ##1 WORK_REG == $past(INSTR.literal, 2);
  endproperty
  a_rlit: assert property (p_rlit)
    else $error("return literal wrong");
endmodule
bind mrr_exec mrr_checker #(.STACK_DEPTH(STACK_DEPTH)) u_chk (.CLK(CLK),
  .RESET(RESET), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
  .INSTR_READY(INSTR_READY), .WORK_REG(WORK_REG), .PC(PC), .FLAGS(FLAGS),
  .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .STACK_LEVEL(STACK_LEVEL),
  .FILE_WRITE(FILE_WRITE));

// [verification/move_rotate_return_exec_tb_top.sv]
// Self-checking bench for the move, rotate and return execution block.
// Assumes the design and its checker are compiled before this file.
`timescale 1ns/1ps
module move_rotate_return_exec_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic valid = 1'b0;
  mrr_pkg::mrr_instr_t instr = '0;
  logic push = 1'b0;
  logic [9:0] push_pc = 10'h000;
  logic irq_clr = 1'b0;
  logic ld = 1'b0;
  logic [5:0] ld_a = 6'h00;
  logic [7:0] ld_d = 8'h00;
  logic ready;
  logic irq_en;
  logic [7:0] work;
  logic [9:0] pc;
  mrr_pkg::mrr_flags_t flags;
  logic [3:0] level;
  mrr_pkg::mrr_wr_t fw;
  logic [9:0] pc_exp = 10'h000;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  mrr_exec u_dut (.CLK(clk), .RESET(reset), .INSTR_VALID(valid),
    .INSTR(instr), .INSTR_READY(ready), .STACK_PUSH(push),
    .STACK_PUSH_PC(push_pc), .IRQ_ENABLE_CLEAR(irq_clr), .FILE_LOAD(ld),
    .FILE_LOAD_ADDR(ld_a), .FILE_LOAD_DATA(ld_d), .WORK_REG(work), .PC(pc),
    .FLAGS(flags), .GLOBAL_IRQ_ENABLE(irq_en), .STACK_LEVEL(level),
    .FILE_WRITE(fw));
  initial forever #20 clk = ~clk;
  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The whole run needs well under 200 cycles; a hang ends at the 2000-cycle limit.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // Wide enough for the longest packed group the scenarios compare.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask
  task automatic ex(input mrr_pkg::mrr_op_t op, input logic [7:0] lit,
    input logic [5:0] a, input logic d);
    @(negedge clk);
    valid = 1'b1;
    instr = '{op, lit, a, d};
    @(negedge clk);
    valid = 1'b0;
    if (op inside {mrr_pkg::OP_NOP, mrr_pkg::OP_LOAD_LITERAL,
      mrr_pkg::OP_COPY_REGISTER, mrr_pkg::OP_ROTATE_LEFT_CARRY,
      mrr_pkg::OP_ROTATE_RIGHT_CARRY}) begin
      pc_exp++;
    end
  endtask
  task automatic side(input logic p, input logic [9:0] v, input logic [5:0] a);
    @(negedge clk);
    push = p;
    push_pc = v;
    ld = !p;
    ld_a = a;
    ld_d = v[7:0];
    @(negedge clk);
    push = 1'b0;
    ld = 1'b0;
  endtask
  task automatic t_rotate();
    side(1'b0, 10'h0A5, 6'h0A);
    ex(mrr_pkg::OP_ROTATE_LEFT_CARRY, 8'h00, 6'h0A, 1'b1);
    chk(fw, {1'b1, 6'h0A, 8'h4A});
    chk(flags, 2'h2);
    side(1'b0, 10'h0A5, 6'h0B);
    ex(mrr_pkg::OP_ROTATE_RIGHT_CARRY, 8'h00, 6'h0B, 1'b0);
    chk({fw.strobe, work}, 9'h0D2);
    side(1'b0, 10'h002, 6'h0C);
    ex(mrr_pkg::OP_ROTATE_RIGHT_CARRY, 8'h00, 6'h0C, 1'b1);
    chk({fw.data, flags}, 10'h204);
    ex(mrr_pkg::OP_ROTATE_LEFT_CARRY, 8'h00, 6'h0C, 1'b0);
    chk({work, flags}, 10'h00A);
    chk(pc, pc_exp);
  endtask
  task automatic t_copy();
    side(1'b0, 10'h000, 6'h3F);
    side(1'b0, 10'h03C, 6'h06);
    ex(mrr_pkg::OP_COPY_REGISTER, 8'h00, 6'h3F, 1'b0);
    chk({work, flags}, 10'h003);
    ex(mrr_pkg::OP_COPY_REGISTER, 8'h00, 6'h06, 1'b1);
    chk(fw, {1'b1, 6'h06, 8'h3C});
    chk({work, flags}, 10'h002);
  endtask
  task automatic t_literal();
    ex(mrr_pkg::OP_LOAD_LITERAL, 8'hA5, 6'h00, 1'b0);
    chk({work, flags}, 10'h296);
    ex(mrr_pkg::OP_NOP, 8'h00, 6'h00, 1'b0);
    chk({fw.strobe, work, flags}, 11'h296);
    chk(pc, pc_exp);
  endtask
  task automatic t_returns();
    mrr_pkg::mrr_op_t ops [3] = '{mrr_pkg::OP_SUBROUTINE_EXIT,
      mrr_pkg::OP_EXIT_WITH_LITERAL, mrr_pkg::OP_INTERRUPT_EXIT};
    logic [9:0] tops [3] = '{10'h3FF, 10'h2A5, 10'h123};
    logic [10:0] exp_tail;
    side(1'b1, 10'h123, 6'h00);
    side(1'b1, 10'h2A5, 6'h00);
    side(1'b1, 10'h3FF, 6'h00);
    for (int i = 0; i < 3; i++) begin
      irq_clr = 1'b1;
      ex(ops[i], 8'h5A, 6'h00, 1'b0);
      irq_clr = 1'b0;
      chk({ready, pc}, {1'b0, pc_exp});
      @(negedge clk);
      pc_exp = tops[i];
      chk({ready, pc}, {1'b1, pc_exp});
      chk(level, 4'(2 - i));
      exp_tail = {i != 0, (i == 0) ? 8'hA5 : 8'h5A, 2'h2};
      chk({irq_en, work, flags}, exp_tail);
    end
    ex(mrr_pkg::OP_NOP, 8'h00, 6'h00, 1'b0);
    chk(pc, 10'h124);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    chk({ready, irq_en, level, pc, flags}, 18'h20000);
    chk({work, fw}, 23'h0);
    t_rotate();
    t_copy();
    t_literal();
    t_returns();
    tally_and_finish();
  end
endmodule
